// >>> logic/mhrp_host.sv
// Functional notes
// [R1] sync style: address and chip select low are set up before any strobe
// [R2] sync read: direction high, device acknowledge marks data valid
// [R3] sync read ends by returning chip select high after acknowledge
// [R4] sync write: direction low first, then shared strobe low
// [R5] device stores write data then acknowledges
// [R6] sync write ends with shared strobe and chip select both high
// [R7] device acknowledges within 90 ns of the shared strobe
// [R8] separate style read: acknowledge within 90 ns, strobe held at least 90 ns
// [R9] separate style write: acknowledge within 90 ns, strobe held at least 90 ns
// [R10] latch enable high at least 10 ns, strobe at least 5 ns after it falls
// [R11] latch enable tied high: strobe at least 65 ns after chip select falls
// [R12] address/data style: data strobe on read pin, held 90 ns, acked in 90 ns
// [R13] address/data style: address strobe never falls before chip select
// [R14] device decodes fourteen channel groups of sixteen registers
// [R15] global registers act on all fourteen channels
// [R16] factory test offsets are plain read/write locations
// [R17] one register holds line termination settings
// [R18] channel register 0: pattern type, direction, receiver on, equalizer
// [R19] channel register 1: terminations, jitter select, bandwidth, fifo size
// [R20] channel register 2: invert, transmit test, transmitter on, loopback
// [R21] channel register 3: code, resistor, error inserts, ratio; top two reserved
// [R22] channel register 4: six interrupt enables, bits 7 and 3 reserved
// [R23] separate style: address captured on latch enable falling edge
// [R24] host without latch signal holds latch enable permanently high
// [R25] pattern type select: zero quasi-random, one pseudo-random, resets zero
// [R26] device keeps completion deasserted while chip select high
// [R27] reserved bits read zero and ignore writes
`timescale 1ns/1ns
module mhrp_host #(
  parameter int ACK_WAIT = mhrp_pkg::ACK_WAIT_DEF
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [3:0]        sw_addr,
  input  wire logic [7:0]        sw_wdata,
  input  wire logic              sw_wr,
  input  wire logic              sw_rd,
  output      logic [7:0]        sw_rdata_q,
  output      mhrp_pkg::mhrp_pins_t pins_q,
  output      logic              bus_clk_q,
  input  wire logic              dev_ack_n,
  input  wire logic [7:0]        dev_data_in
);
  import mhrp_pkg::*;

  mhrp_state_t st_q;
  mhrp_state_t st_d;
  logic [7:0]  cnt_q;
  logic [7:0]  taddr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic        read_q;
  logic        done_q;
  logic        tout_q;
  logic [2:0]  cfg_q;
  logic        ack_m_q;
  logic        ack_s_q;
  logic [7:0]  din_m_q;
  logic [7:0]  din_s_q;
  logic        go;
  logic        last_setup;
  logic        ack_ok;
  logic        wait_over;
  logic        finish;
  logic        dir_rd;
  mhrp_mode_t  mode;
  logic        use_ale;
  mhrp_pins_t  pins_d;

  assign mode    = mhrp_mode_t'(cfg_q[1:0]);
  assign use_ale = cfg_q[CFG_ALE_BIT];
  assign go      = sw_wr && (sw_addr == SW_CMD) && sw_wdata[CMD_GO_BIT] && (st_q == ST_IDLE);
  // direction of the transfer being launched, so setup pins already carry it
  assign dir_rd  = go ? sw_wdata[CMD_READ_BIT] : read_q;

  // pin inputs pass two flops before use
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_m_q <= 1'b1;
      ack_s_q <= 1'b1;
      din_m_q <= 8'h00;
      din_s_q <= 8'h00;
    end else begin
      ack_m_q <= dev_ack_n;
      ack_s_q <= ack_m_q;
      din_m_q <= dev_data_in;
      din_s_q <= din_m_q;
    end
  end

  // synchronous style bus clock, divided from clock
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_clk_q <= 1'b0;
    end else begin
      bus_clk_q <= ~bus_clk_q;
    end
  end

  always_comb begin
    if (mode == MODE_SEP && use_ale) begin
      last_setup = (cnt_q + 8'd1) >= 8'(ALE_W_CYC); // [R10]
    end else if (mode == MODE_SYNC) begin
      last_setup = 1'b1; // [R1]
    end else begin
      last_setup = (cnt_q + 8'd1) >= 8'(CS_STB_CYC); // [R11] [R13]
    end
  end

  // acknowledge is awaited with a bound; the device answers in 90 ns
  assign ack_ok    = !ack_s_q && ((cnt_q + 8'd1) >= 8'(STB_W_CYC)); // [R7] [R8] [R9] [R12]
  assign wait_over = (cnt_q + 8'd1) >= 8'(ACK_WAIT);
  assign finish    = (st_q == ST_RELEASE) && (ack_s_q || wait_over); // [R26]

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (go) st_d = ST_SETUP;
      end
      ST_SETUP: begin
        if (last_setup) st_d = (mode == MODE_SEP && use_ale) ? ST_LATCH : ST_STROBE;
      end
      ST_LATCH: begin
        if ((cnt_q + 8'd1) >= 8'(ALE_STB_CYC)) st_d = ST_STROBE; // [R10] [R23]
      end
      ST_STROBE: begin
        if (ack_ok || wait_over) st_d = ST_RELEASE;
      end
      ST_RELEASE: begin
        if (finish) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q  <= ST_IDLE;
      cnt_q <= 8'h00;
    end else begin
      st_q  <= st_d;
      cnt_q <= (st_d != st_q) ? 8'h00 : cnt_q + 8'd1;
    end
  end

  // pin levels follow the next state so that pins_q lines up with st_q
  always_comb begin
    pins_d           = '0;
    pins_d.addr      = {3'b000, taddr_q};
    pins_d.cs_n      = 1'b1;
    pins_d.rd_n      = 1'b1;
    pins_d.wr_n      = 1'b1;
    pins_d.ale       = (mode == MODE_ADS) ? 1'b1 : (mode == MODE_SEP && !use_ale); // [R24]
    pins_d.data_out  = wdata_q;
    pins_d.data_oe_n = 1'b1;
    if (st_d != ST_IDLE && st_d != ST_RELEASE) begin
      pins_d.cs_n      = 1'b0; // [R1]
      pins_d.data_oe_n = dir_rd;
      if (mode == MODE_SEP && use_ale) begin
        pins_d.ale = (st_d == ST_SETUP); // [R10]
      end else if (mode == MODE_SYNC) begin
        pins_d.ale = (st_d == ST_SETUP);
      end else if (mode == MODE_ADS) begin
        pins_d.ale = 1'b0; // [R13]
      end
      if (mode == MODE_SEP) begin
        pins_d.rd_n = !(st_d == ST_STROBE && dir_rd); // [R8]
        pins_d.wr_n = !(st_d == ST_STROBE && !dir_rd); // [R9]
      end else begin
        pins_d.wr_n = dir_rd; // [R2] [R4]
        pins_d.rd_n = (st_d != ST_STROBE); // [R4] [R12]
      end
    end else if (st_d == ST_RELEASE && mode != MODE_SEP) begin
      pins_d.wr_n = dir_rd; // [R3] [R6]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pins_q <= '{addr: 11'h000, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0,
                  data_out: 8'h00, data_oe_n: 1'b1};
    end else begin
      pins_q <= pins_d;
    end
  end

  // software registers
  always_ff @(posedge clock) begin
    if (rst) begin
      taddr_q <= TADDR_RST;
      wdata_q <= WDATA_RST;
      cfg_q   <= CFG_RST;
      read_q  <= 1'b0;
    end else begin
      if (go) read_q <= sw_wdata[CMD_READ_BIT];
      if (sw_wr && sw_addr == SW_TADDR && st_q == ST_IDLE) taddr_q <= sw_wdata;
      if (sw_wr && sw_addr == SW_WDATA && st_q == ST_IDLE) wdata_q <= sw_wdata;
      if (sw_wr && sw_addr == SW_CFG && st_q == ST_IDLE) cfg_q <= sw_wdata[2:0];
    end
  end

  // read data captured on acknowledge; data path synchronised with it
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (st_q == ST_STROBE && ack_ok && read_q) begin
      rdata_q <= din_s_q; // [R2]
    end
  end

  // sticky flags: hardware set wins over software clear
  always_ff @(posedge clock) begin
    if (rst) begin
      done_q <= 1'b0;
      tout_q <= 1'b0;
    end else begin
      if (finish) begin
        done_q <= 1'b1;
      end else if (sw_wr && sw_addr == SW_STATUS && sw_wdata[ST_DONE_BIT]) begin
        done_q <= 1'b0;
      end
      if ((st_q == ST_STROBE && !ack_ok && wait_over) || (finish && !ack_s_q)) begin
        tout_q <= 1'b1;
      end else if (sw_wr && sw_addr == SW_STATUS && sw_wdata[ST_TOUT_BIT]) begin
        tout_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sw_rdata_q <= 8'h00;
    end else if (sw_rd) begin
      unique case (sw_addr)
        SW_CMD:    sw_rdata_q <= {6'h00, read_q, 1'b0};
        SW_TADDR:  sw_rdata_q <= taddr_q;
        SW_WDATA:  sw_rdata_q <= wdata_q;
        SW_RDATA:  sw_rdata_q <= rdata_q;
        SW_STATUS: sw_rdata_q <= {5'h00, tout_q, done_q, st_q != ST_IDLE};
        SW_CFG:    sw_rdata_q <= {5'h00, cfg_q};
        default:   sw_rdata_q <= 8'h00;
      endcase
    end else begin
      sw_rdata_q <= 8'h00;
    end
  end

  // helper counters for the checks below
  logic [7:0] cs_low_cnt_q;
  logic [7:0] stb_low_cnt_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      cs_low_cnt_q  <= 8'h00;
      stb_low_cnt_q <= 8'h00;
    end else begin
      cs_low_cnt_q  <= pins_q.cs_n ? 8'h00 : cs_low_cnt_q + 8'd1;
      stb_low_cnt_q <= (pins_q.rd_n && (pins_q.wr_n || mode != MODE_SEP)) ? 8'h00 : stb_low_cnt_q + 8'd1;
    end
  end

  property p_sync_strobe_needs_cs;
    @(posedge clock) disable iff (rst)
      (mode == MODE_SYNC && !pins_q.rd_n) |-> (!pins_q.cs_n && cs_low_cnt_q >= 8'd1);
  endproperty
  a_sync_strobe_needs_cs: assert property (p_sync_strobe_needs_cs) else $error("strobe without cs setup"); // [R1]

  property p_sync_read_dir;
    @(posedge clock) disable iff (rst)
      (mode == MODE_SYNC && read_q && !pins_q.rd_n) |-> pins_q.wr_n;
  endproperty
  a_sync_read_dir: assert property (p_sync_read_dir) else $error("sync read with direction low"); // [R2]

  property p_sync_write_order;
    @(posedge clock) disable iff (rst)
      (mode == MODE_SYNC && !read_q && $fell(pins_q.rd_n)) |-> ($past(pins_q.wr_n) == 1'b0);
  endproperty
  a_sync_write_order: assert property (p_sync_write_order) else $error("direction not low before strobe"); // [R4]

  property p_release_ends_cycle;
    @(posedge clock) disable iff (rst)
      (st_q == ST_STROBE && st_d == ST_RELEASE) |=>
        (pins_q.cs_n && pins_q.rd_n && pins_q.wr_n == (read_q || mode == MODE_SEP));
  endproperty
  a_release_ends_cycle: assert property (p_release_ends_cycle) else $error("cycle not ended on ack"); // [R3] [R6]

  property p_strobe_width;
    @(posedge clock) disable iff (rst)
      (stb_low_cnt_q != 8'd0 && pins_q.rd_n && (pins_q.wr_n || mode != MODE_SEP)) |->
        stb_low_cnt_q >= 8'(STB_W_CYC);
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe too short"); // [R8] [R9] [R12]

  property p_ale_to_strobe;
    @(posedge clock) disable iff (rst)
      (mode == MODE_SEP && use_ale && $fell(pins_q.ale)) |-> (pins_q.rd_n && pins_q.wr_n);
  endproperty
  a_ale_to_strobe: assert property (p_ale_to_strobe) else $error("strobe too soon after latch"); // [R10]

  property p_cs_to_strobe;
    @(posedge clock) disable iff (rst)
      ((mode == MODE_SEP && !use_ale || mode == MODE_ADS) &&
       ($fell(pins_q.rd_n) || (mode == MODE_SEP && $fell(pins_q.wr_n))))
        |-> cs_low_cnt_q >= 8'(CS_STB_CYC);
  endproperty
  a_cs_to_strobe: assert property (p_cs_to_strobe) else $error("strobe too soon after cs"); // [R11]

  property p_as_after_cs;
    @(posedge clock) disable iff (rst)
      (mode == MODE_ADS && $past(mode) == MODE_ADS && !pins_q.ale) |-> !pins_q.cs_n;
  endproperty
  a_as_after_cs: assert property (p_as_after_cs) else $error("address strobe before cs"); // [R13]

  property p_ale_tied;
    @(posedge clock) disable iff (rst)
      (mode == MODE_SEP && !use_ale && st_q != ST_IDLE) |-> pins_q.ale;
  endproperty
  a_ale_tied: assert property (p_ale_tied) else $error("latch enable not held high"); // [R24]

  property p_sync_release;
    @(posedge clock) disable iff (rst)
      (mode == MODE_SYNC && $rose(pins_q.rd_n)) |-> pins_q.cs_n;
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("shared strobe released without cs"); // [R6]

  property p_sep_single_strobe;
    @(posedge clock) disable iff (rst)
      (mode == MODE_SEP) |-> (pins_q.rd_n || pins_q.wr_n);
  endproperty
  a_sep_single_strobe: assert property (p_sep_single_strobe) else $error("both strobes low"); // [R8] [R9]

  property p_write_data_driven;
    @(posedge clock) disable iff (rst)
      (!read_q && st_q == ST_STROBE) |-> !pins_q.data_oe_n;
  endproperty
  a_write_data_driven: assert property (p_write_data_driven) else $error("write data not driven"); // [R4] [R9]

  property p_read_no_drive;
    @(posedge clock) disable iff (rst)
      (read_q && st_q != ST_IDLE) |-> pins_q.data_oe_n;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) else $error("data bus driven during read"); // [R2]

  c_sep_read:   cover property (@(posedge clock) disable iff (rst) mode == MODE_SEP && !pins_q.rd_n ##[1:20] finish);
  c_sync_write: cover property (@(posedge clock) disable iff (rst) mode == MODE_SYNC && !read_q && !pins_q.rd_n);
  c_ads_read:   cover property (@(posedge clock) disable iff (rst) mode == MODE_ADS && read_q && !pins_q.rd_n);
  c_timeout:    cover property (@(posedge clock) disable iff (rst) $rose(tout_q));

endmodule : mhrp_host

// >>> logic/mhrp_pkg.sv
package mhrp_pkg;

  // software-side register offsets
  localparam logic [3:0] SW_CMD    = 4'h0;
  localparam logic [3:0] SW_TADDR  = 4'h1;
  localparam logic [3:0] SW_WDATA  = 4'h2;
  localparam logic [3:0] SW_RDATA  = 4'h3;
  localparam logic [3:0] SW_STATUS = 4'h4;
  localparam logic [3:0] SW_CFG    = 4'h5;

  // field positions
  localparam int CMD_GO_BIT   = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_DONE_BIT  = 1;
  localparam int ST_TOUT_BIT  = 2;
  localparam int CFG_ALE_BIT  = 2;

  // reset values
  localparam logic [7:0] TADDR_RST = 8'h00;
  localparam logic [7:0] WDATA_RST = 8'h00;
  localparam logic [2:0] CFG_RST   = 3'h4;

  // device register map
  localparam logic [7:0] DEV_CH_STRIDE     = 8'h10;
  localparam int         DEV_NUM_CH        = 14;
  localparam logic [7:0] DEV_CH_PATTERN_EQ = 8'h00;
  localparam logic [7:0] DEV_CH_TERM_JIT   = 8'h01;
  localparam logic [7:0] DEV_CH_TEST_LOOP  = 8'h02;
  localparam logic [7:0] DEV_CH_CODE_ERR   = 8'h03;
  localparam logic [7:0] DEV_CH_IRQ_EN     = 8'h04;
  localparam logic [7:0] DEV_GLOBAL_FIRST  = 8'hE0;
  localparam logic [7:0] DEV_GLOBAL_LAST   = 8'hEB;
  localparam logic [7:0] DEV_TEST_A_FIRST  = 8'hEC;
  localparam logic [7:0] DEV_TEST_A_LAST   = 8'hF3;
  localparam logic [7:0] DEV_GLOBAL_EXTRA  = 8'hF4;
  localparam logic [7:0] DEV_LINE_TERM     = 8'hF5;
  localparam logic [7:0] DEV_TEST_B_FIRST  = 8'hF6;
  localparam logic [7:0] DEV_TEST_B_LAST   = 8'hFD;
  localparam logic [7:0] DEV_IDENTITY      = 8'hFE;
  localparam logic [7:0] DEV_REVISION      = 8'hFF;
  localparam logic [7:0] DEV_CH3_RSVD_MASK = 8'hC0;
  localparam logic [7:0] DEV_CH4_RSVD_MASK = 8'h88;

  // timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int T_CS_TO_STB_NS  = 65;
  localparam int T_ALE_WIDTH_NS  = 10;
  localparam int T_ALE_TO_STB_NS = 5;
  localparam int T_STB_WIDTH_NS  = 90;
  localparam int T_ACK_MAX_NS    = 90;

  localparam int CS_STB_RAW  = (T_CS_TO_STB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_STB_CYC  = (CS_STB_RAW < 1) ? 1 : CS_STB_RAW;
  localparam int ALE_W_RAW   = (T_ALE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALE_W_CYC   = (ALE_W_RAW < 1) ? 1 : ALE_W_RAW;
  localparam int ALE_STB_RAW = (T_ALE_TO_STB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALE_STB_CYC = (ALE_STB_RAW < 1) ? 1 : ALE_STB_RAW;
  localparam int STB_W_RAW   = (T_STB_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STB_W_CYC   = (STB_W_RAW < 1) ? 1 : STB_W_RAW;
  localparam int ACK_MAX_RAW = T_ACK_MAX_NS / CLK_PERIOD_NS;
  localparam int ACK_MAX_CYC = (ACK_MAX_RAW < 1) ? 1 : ACK_MAX_RAW;
  localparam int ACK_WAIT_DEF = ACK_MAX_CYC + 6;

  typedef enum logic [1:0] {
    MODE_SEP  = 2'b00,
    MODE_SYNC = 2'b01,
    MODE_ADS  = 2'b10
  } mhrp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETUP   = 3'b001,
    ST_LATCH   = 3'b010,
    ST_STROBE  = 3'b011,
    ST_RELEASE = 3'b100
  } mhrp_state_t;

  typedef struct packed {
    logic [10:0] addr;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        ale;
    logic [7:0]  data_out;
    logic        data_oe_n;
  } mhrp_pins_t;

endpackage : mhrp_pkg

// >>> verif/mhrp_dev_model.sv
`timescale 1ns/1ns
module mhrp_dev_model #(
  parameter logic [7:0] ID_CODE  = 8'h3C,  // arbitrary value
  parameter logic [7:0] REV_CODE = 8'h01   // arbitrary value
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire mhrp_pkg::mhrp_pins_t pins,
  input  wire mhrp_pkg::mhrp_mode_t mode,
  input  wire logic [3:0]           ack_delay,
  output      logic                 ack_n,
  output      logic [7:0]           data_in,
  output      logic [7:0]           viol
);
  import mhrp_pkg::*;
  logic [7:0] mem [256];
  logic [7:0] lat_q;
  logic [7:0] noise_q;
  logic [3:0] cnt_q;
  logic       cs_q;
  logic       stb;
  logic       is_rd;
  logic [7:0] a;

  function automatic logic [7:0] wmask(input logic [7:0] ad);
    if (ad >= DEV_GLOBAL_FIRST) return 8'hFF;
    if (ad[3:0] == 4'h3) return ~DEV_CH3_RSVD_MASK;
    if (ad[3:0] == 4'h4) return ~DEV_CH4_RSVD_MASK;
    return 8'hFF;
  endfunction : wmask

  assign stb   = (mode == MODE_SEP) ? !(pins.rd_n && pins.wr_n) : !pins.rd_n;
  assign is_rd = (mode == MODE_SEP) ? !pins.rd_n : pins.wr_n;
  // address register reloads on every clock edge while the latch enable is high
  assign a     = (mode == MODE_ADS) ? pins.addr[7:0] : lat_q;
  // prompt answer lands within the same cycle as the strobe
  assign ack_n = !(stb && !pins.cs_n && cnt_q >= ack_delay);
  assign data_in = (!ack_n && is_rd) ? ((a == DEV_IDENTITY) ? ID_CODE :
                   (a == DEV_REVISION) ? REV_CODE : mem[a]) : noise_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'h00;
      lat_q <= 8'h00;
      noise_q <= 8'h55;
      cnt_q <= 4'h0;
      cs_q <= 1'b1;
      viol <= 8'h00;
    end else begin
      noise_q <= ~noise_q;
      cs_q <= pins.cs_n;
      cnt_q <= (stb && !pins.cs_n) ? cnt_q + 4'h1 : 4'h0;
      if (pins.ale) lat_q <= pins.addr[7:0];
      // strobe before chip select settled, address strobe early, undriven write data
      if (stb && (pins.cs_n || cs_q)) viol <= viol + 8'h01;
      if (mode == MODE_ADS && !pins.ale && pins.cs_n) viol <= viol + 8'h01;
      if (stb && !is_rd && pins.data_oe_n) viol <= viol + 8'h01;
      if (stb && !pins.cs_n && cnt_q == 4'h0 && !is_rd && a < DEV_IDENTITY)
        mem[a] <= pins.data_out & wmask(a);
    end
  end
endmodule : mhrp_dev_model

// >>> verif/test_mhrp_host.sv
`timescale 1ns/1ns
module test_mhrp_host;
  import mhrp_pkg::*;
  localparam logic [7:0] DEV_ID  = 8'h3C;  // arbitrary value
  localparam logic [7:0] DEV_REV = 8'h01;  // arbitrary value
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic       sw_wr = 1'b0;
  logic       sw_rd = 1'b0;
  logic [7:0] sw_rdata_q;
  mhrp_pins_t pins_q;
  logic       bus_clk_q;
  logic       dev_ack_n;
  logic [7:0] dev_data_in;
  mhrp_mode_t mode = MODE_SEP;
  logic [3:0] ack_delay = 4'h0;
  logic [7:0] viol;
  logic [7:0] rd;
  int         fail_count = 0;
  int         check_count = 0;
  int         cycles = 0;
  logic [2:0] cfgs [4] = '{3'h4, 3'h0, 3'h1, 3'h2};
  logic [7:0] regs [10] = '{8'h00, 8'h01, 8'h53, 8'hD4, 8'hE0, 8'hEC, 8'hF4, 8'hF5, 8'hFD, 8'hFE};
  logic [7:0] exps [10] = '{8'hFF, 8'hFF, 8'h3F, 8'h77, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, DEV_ID};

  mhrp_host #(.ACK_WAIT(4)) mhrp_host_i (
    .clock(clock), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata_q(sw_rdata_q), .pins_q(pins_q), .bus_clk_q(bus_clk_q), .dev_ack_n(dev_ack_n),
    .dev_data_in(dev_data_in));
  mhrp_dev_model #(.ID_CODE(DEV_ID), .REV_CODE(DEV_REV)) mhrp_dev_model_i (
    .clock(clock), .rst(rst), .pins(pins_q), .mode(mode), .ack_delay(ack_delay),
    .ack_n(dev_ack_n), .data_in(dev_data_in), .viol(viol));

  always #50 clock = ~clock;

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic sw_write(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clock);
    sw_addr <= ad;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask : sw_write

  task automatic sw_read(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clock);
    sw_addr <= ad;
    sw_rd <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    @(negedge clock);
    d = sw_rdata_q;
  endtask : sw_read

  // one device transfer driven through the software port
  task automatic access(input logic is_rd, input logic [7:0] ta, input logic [7:0] wd,
                        input logic tout, output logic [7:0] d);
    logic [7:0] st;
    int         n;
    st = 8'h00;
    n = 0;
    sw_write(SW_TADDR, ta);
    sw_write(SW_WDATA, wd);
    sw_write(SW_CMD, is_rd ? 8'h03 : 8'h01);
    while (st[ST_DONE_BIT] !== 1'b1 && n < 40) begin
      sw_read(SW_STATUS, st);
      n++;
    end
    check("status", tout ? 8'h06 : 8'h02, st & 8'h07);
    sw_read(SW_RDATA, d);
    sw_write(SW_STATUS, 8'h06);
  endtask : access

  task automatic set_cfg(input logic [2:0] c);
    sw_write(SW_CFG, {5'h00, c});
    // pins show the new style one edge after the write lands
    @(posedge clock);
    mode <= mhrp_mode_t'(c[1:0]);
    @(posedge clock);
  endtask : set_cfg

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    sw_read(SW_CFG, rd);
    check("cfg reset", {5'h00, CFG_RST}, rd);
    // bus clock halves the system clock, low while reset is held
    repeat (2) begin
      check("bus clock", {7'h00, ~cycles[0]}, {7'h00, bus_clk_q});
      @(negedge clock);
    end
    sw_read(4'hF, rd);
    check("unmapped", 8'h00, rd);
    access(1'b1, DEV_CH_PATTERN_EQ, 8'h00, 1'b0, rd);
    check("pattern type reset", 8'h00, {7'h00, rd[7]});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      set_cfg(cfgs[i]);
      access(1'b0, 8'(i * 64 + 16) + DEV_CH_TEST_LOOP, 8'hA0 + 8'(i), 1'b0, rd);
      access(1'b1, 8'(i * 64 + 16) + DEV_CH_TEST_LOOP, 8'h00, 1'b0, rd);
      check("readback", 8'hA0 + 8'(i), rd);
      access(1'b1, DEV_REVISION, 8'h00, 1'b0, rd);
      check("revision", DEV_REV, rd);
      $display("test mode %0d done", i);
    end
    for (int i = 0; i < 4; i++) begin
      access(1'b1, 8'(i * 64 + 16) + DEV_CH_TEST_LOOP, 8'h00, 1'b0, rd);
      check("channel decode", 8'hA0 + 8'(i), rd);
    end
    $display("test decode done");
    set_cfg(3'h4);
    for (int i = 0; i < 10; i++) begin
      access(1'b0, regs[i], 8'hFF, 1'b0, rd);
      access(1'b1, regs[i], 8'h00, 1'b0, rd);
      check("register", exps[i], rd);
    end
    $display("test register map done");
    ack_delay <= 4'h6;
    access(1'b1, DEV_LINE_TERM, 8'h00, 1'b1, rd);
    ack_delay <= 4'h1;
    access(1'b1, DEV_LINE_TERM, 8'h00, 1'b0, rd);
    check("slow read", 8'hFF, rd);
    ack_delay <= 4'h0;
    sw_read(SW_STATUS, rd);
    check("status cleared", 8'h00, rd);
    check("wire order faults", 8'h00, viol);
    $display("test slow device done");
    conclude();
  end
endmodule : test_mhrp_host
